// ==== rtl/cbpm_pkg.sv ====
// Package for the CardBus power-management register bank.
// Assumes one 40 MHz clock domain and byte addresses in configuration space.
package cbpm_pkg;

    // Configuration dword and register byte addresses.
    localparam logic [7:0] CAP_DWORD_ADDR   = 8'hA0;
    localparam logic [7:0] CTRL_DWORD_ADDR  = 8'hA4;
    localparam logic [7:0] CAP_REG_OFFSET   = 8'hA2;
    localparam logic [7:0] CTRL_REG_OFFSET  = 8'hA4;
    localparam logic [7:0] EXT_REG_OFFSET   = 8'hA6;
    localparam logic [7:0] DATA_REG_OFFSET  = 8'hA7;

    // Field positions of the power control/status register.
    localparam int WAKE_FLAG_BIT    = 15;
    localparam int DATA_SCALE_HI    = 14;
    localparam int DATA_SCALE_LO    = 13;
    localparam int DATA_SELECT_HI   = 12;
    localparam int DATA_SELECT_LO   = 9;
    localparam int WAKE_EN_BIT      = 8;
    localparam int POWER_STATE_HI   = 1;
    localparam int POWER_STATE_LO   = 0;

    // Field positions of the bridge extension register.
    localparam int BUS_CTRL_ON_BIT  = 7;
    localparam int D3HOT_ACTION_BIT = 6;

    // Field position of the writable wake-from-D3cold capability bit.
    localparam int CAP_D3COLD_BIT   = 15;

    // Reset and fixed values.
    localparam logic [15:0] CAP_RESET_VALUE  = 16'hFE12;
    localparam logic [15:0] CTRL_RESET_VALUE = 16'h0000;
    localparam logic [7:0]  EXT_VALUE        = 8'hC0;
    localparam logic [7:0]  DATA_VALUE       = 8'h00;

    // Synchroniser depth for pins.
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        CBPM_D0    = 2'b00,
        CBPM_D1    = 2'b01,
        CBPM_D2    = 2'b10,
        CBPM_D3HOT = 2'b11
    } cbpm_power_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cbpm_cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } cbpm_cfg_rsp_t;

endpackage

// ==== rtl/cbpm_pin_sync.sv ====
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the pins are levels that stay put for several clock cycles.
`timescale 1ns/1ps
module cbpm_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] reset_val_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // The first stage feeds only the second stage.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    meta_reg[g] <= 1'b1;
                    sync_reg[g] <= 1'b1;
                end else begin
                    meta_reg[g] <= async_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    // During reset the caller's idle value is shown instead of the constant ones.
    always_comb begin
        sync_o = rst_b_i ? sync_reg : reset_val_i;
    end

endmodule

// ==== rtl/cbpm_regs.sv ====
// Power-management control and status registers of a CardBus bridge function.
// Assumes configuration accesses arrive as one-cycle strobes on clk_i, and that
// rst_b_i is the global reset while the bus reset arrives on a pin.
`timescale 1ns/1ps

// Function
// (RL1) Control/status survives the D3hot-to-D0 internal reset.
// (RL2) D3hot-to-D0 resets function registers, keeping exceptions.
// (RL3) Wake event sets status flag regardless of enable.
// (RL4) Writing one clears flag and wake output.
// (RL5) Data scale field reads zero.
// (RL6) Data select field reads zero.
// (RL7) Enable gates wake; only global reset clears.
// (RL8) Power state field reads and sets state.
// (RL9) Wake context cleared by bus reset only if disabled.
// (RL10) Reserved bits of both registers read zero.
// (RL11) Bus power/clock control bit reads one.
// (RL12) Without bus control, state leaves secondary bus alone.
// (RL13) Action bit reads one: D3hot stops secondary clock.
// (RL14) Action bit matters only with bus control on.
// (RL15) D3cold wake capability writable, global reset only.
// (RL16) Writes to read-only fields are ignored.
module cbpm_regs #(
    parameter logic [15:0] CAP_HEADER = 16'h0000
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   pci_bus_reset_pin_b_i,
    input  wire cbpm_pkg::cbpm_cfg_req_t cfg_req_i,
    output cbpm_pkg::cbpm_cfg_rsp_t     cfg_rsp_o,
    input  wire logic                   wake_event_i,
    output logic                        wake_pin_o,
    output logic                        wake_pin_oe_b_o,
    output logic [1:0]                  power_state_o,
    output logic                        func_reset_o,
    output logic                        wake_context_keep_o,
    output logic                        sec_clock_stop_o,
    output logic                        sec_power_off_o
);

    logic       bus_reset_sync;
    logic       bus_reset_act;
    logic [1:0] power_state_field_reg;
    logic       wake_enable_bit_reg;
    logic       wake_event_flag_reg;
    logic       cap_d3cold_reg;
    logic       func_reset_reg;
    logic       ctrl_hit;
    logic       cap_hit;
    logic       d3hot_to_d0;
    logic       flag_clear;
    logic       state_wr;
    logic       lane1_wr;
    logic [1:0] power_state_field_next;
    logic       wake_enable_bit_next;
    logic       wake_event_flag_next;
    logic       wake_pin_oe_b_reg;
    logic       sec_clock_stop_reg;
    logic       sec_power_off_reg;
    logic       bus_power_clock_ctrl_on;
    logic       d3hot_bus_action_select;
    logic [15:0] ctrl_value;
    logic [15:0] cap_value;
    logic [31:0] rdata_next;
    cbpm_pkg::cbpm_cfg_rsp_t rsp_reg;

    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] base);
        dword_hit = (addr[7:2] == base[7:2]);
    endfunction

    function automatic logic is_d3hot(input logic [1:0] state);
        is_d3hot = (state == cbpm_pkg::CBPM_D3HOT);
    endfunction

    cbpm_pin_sync #(
        .WIDTH (1)
    ) u_bus_reset_sync (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .async_i     (pci_bus_reset_pin_b_i),
        .reset_val_i (1'b1),
        .sync_o      (bus_reset_sync)
    );

    assign bus_reset_act = !bus_reset_sync;
    assign ctrl_hit      = cfg_req_i.wr && dword_hit(cfg_req_i.addr, cbpm_pkg::CTRL_DWORD_ADDR);
    assign cap_hit       = cfg_req_i.wr && dword_hit(cfg_req_i.addr, cbpm_pkg::CAP_DWORD_ADDR);

    // Fixed bridge extension bits.
    assign bus_power_clock_ctrl_on = cbpm_pkg::EXT_VALUE[cbpm_pkg::BUS_CTRL_ON_BIT]; // RL11
    assign d3hot_bus_action_select = cbpm_pkg::EXT_VALUE[cbpm_pkg::D3HOT_ACTION_BIT]; // RL13

    // Byte-lane write strobes of the control/status dword.
    assign state_wr = ctrl_hit && cfg_req_i.be[0];
    assign lane1_wr = ctrl_hit && cfg_req_i.be[1];

    assign d3hot_to_d0 = state_wr && is_d3hot(power_state_field_reg)
                         && (cfg_req_i.wdata[1:0] == cbpm_pkg::CBPM_D0);

    assign flag_clear = lane1_wr && cfg_req_i.wdata[cbpm_pkg::WAKE_FLAG_BIT]; // RL4

    // Power state: the internal reset never touches it, only the bus and global resets do.
    always_comb begin
        power_state_field_next = power_state_field_reg;
        if (bus_reset_act) begin
            power_state_field_next = cbpm_pkg::CBPM_D0;
        end else if (state_wr) begin
            power_state_field_next = cfg_req_i.wdata[1:0]; // RL8 RL1
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_state_field_reg <= cbpm_pkg::CBPM_D0;
        end else begin
            power_state_field_reg <= power_state_field_next;
        end
    end

    // Wake enable is cleared only by the global reset.
    always_comb begin
        wake_enable_bit_next = wake_enable_bit_reg;
        if (lane1_wr) begin
            wake_enable_bit_next = cfg_req_i.wdata[cbpm_pkg::WAKE_EN_BIT]; // RL7
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_enable_bit_reg <= 1'b0;
        end else begin
            wake_enable_bit_reg <= wake_enable_bit_next;
        end
    end

    // Wake status flag; a new event wins over a clear in the same cycle.
    always_comb begin
        wake_event_flag_next = wake_event_flag_reg;
        if (wake_event_i) begin
            wake_event_flag_next = 1'b1; // RL3
        end else if (bus_reset_act && !wake_enable_bit_reg) begin
            wake_event_flag_next = 1'b0; // RL9
        end else if (flag_clear) begin
            wake_event_flag_next = 1'b0; // RL4
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_event_flag_reg <= 1'b0;
        end else begin
            wake_event_flag_reg <= wake_event_flag_next;
        end
    end

    // Capability bit kept across bus and internal resets for D3cold wake.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cap_d3cold_reg <= cbpm_pkg::CAP_RESET_VALUE[cbpm_pkg::CAP_D3COLD_BIT];
        end else if (cap_hit && cfg_req_i.be[3]) begin
            cap_d3cold_reg <= cfg_req_i.wdata[31]; // RL15
        end
    end

    // One-cycle reset for the rest of the function, issued a cycle after the write.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            func_reset_reg <= 1'b0;
        end else begin
            func_reset_reg <= d3hot_to_d0; // RL2
        end
    end

    assign func_reset_o        = func_reset_reg; // RL2
    assign wake_context_keep_o = wake_enable_bit_reg; // RL2 RL9
    assign power_state_o       = power_state_field_reg;

    // Pin-level outputs are registered from the next values, so the open-drain enable
    // cannot glitch while flag and enable change together, and no cycle is lost.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_pin_oe_b_reg  <= 1'b1;
            sec_clock_stop_reg <= 1'b0;
            sec_power_off_reg  <= 1'b0;
        end else begin
            wake_pin_oe_b_reg  <= !(wake_event_flag_next && wake_enable_bit_next); // RL7 RL4
            sec_clock_stop_reg <= bus_power_clock_ctrl_on && d3hot_bus_action_select
                                  && is_d3hot(power_state_field_next); // RL12 RL14
            sec_power_off_reg  <= bus_power_clock_ctrl_on && !d3hot_bus_action_select
                                  && is_d3hot(power_state_field_next); // RL12 RL14
        end
    end

    // Open-drain wake pin: enable is low while pulling the wire low.
    assign wake_pin_o       = 1'b0;
    assign wake_pin_oe_b_o  = wake_pin_oe_b_reg;
    assign sec_clock_stop_o = sec_clock_stop_reg;
    assign sec_power_off_o  = sec_power_off_reg;

    // Read-only fields are built from constants, so writes cannot reach them.
    always_comb begin
        ctrl_value = cbpm_pkg::CTRL_RESET_VALUE; // RL5 RL6 RL10 RL16
        ctrl_value[cbpm_pkg::WAKE_FLAG_BIT] = wake_event_flag_reg;
        ctrl_value[cbpm_pkg::WAKE_EN_BIT] = wake_enable_bit_reg;
        ctrl_value[cbpm_pkg::POWER_STATE_HI:cbpm_pkg::POWER_STATE_LO] = power_state_field_reg;
        cap_value = cbpm_pkg::CAP_RESET_VALUE; // RL16
        cap_value[cbpm_pkg::CAP_D3COLD_BIT] = cap_d3cold_reg;
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (dword_hit(cfg_req_i.addr, cbpm_pkg::CTRL_DWORD_ADDR)) begin
            rdata_next = {cbpm_pkg::DATA_VALUE, cbpm_pkg::EXT_VALUE, ctrl_value}; // RL10 RL11
        end else if (dword_hit(cfg_req_i.addr, cbpm_pkg::CAP_DWORD_ADDR)) begin
            rdata_next = {cap_value, CAP_HEADER};
        end
    end

    // Read answer one cycle after the strobe; unmapped dwords read zero.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= cfg_req_i.rd;
            rsp_reg.rdata <= cfg_req_i.rd ? rdata_next : 32'h0000_0000;
        end
    end

    assign cfg_rsp_o = rsp_reg;

endmodule

// ==== dv/cbpm_regs_props.sv ====
// Assertions on the ports of the power-management register bank.
// Assumes the bind below attaches it to every cbpm_regs instance.
`timescale 1ns/1ps
module cbpm_regs_props (
    input wire logic                    clk_i,
    input wire logic                    rst_b_i,
    input wire logic                    pci_bus_reset_pin_b_i,
    input wire cbpm_pkg::cbpm_cfg_req_t cfg_req_i,
    input wire cbpm_pkg::cbpm_cfg_rsp_t cfg_rsp_o,
    input wire logic                    wake_event_i,
    input wire logic                    wake_pin_o,
    input wire logic                    wake_pin_oe_b_o,
    input wire logic [1:0]              power_state_o,
    input wire logic                    func_reset_o,
    input wire logic                    wake_context_keep_o,
    input wire logic                    sec_clock_stop_o,
    input wire logic                    sec_power_off_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_rd;
        cfg_req_i.rd && cfg_req_i.addr[7:2] == 6'h29;
    endsequence
    sequence s_wr_lo;
        cfg_req_i.wr && cfg_req_i.addr[7:2] == 6'h29 && cfg_req_i.be[0];
    endsequence
    a_data_zero: assert property (s_rd |=> cfg_rsp_o.rdata[14:9] == 6'h00)
        else $error("data fields not zero");
    a_reserved_zero: assert property (s_rd |=> cfg_rsp_o.rdata[7:2] == 6'h00
        && cfg_rsp_o.rdata[21:16] == 6'h00) else $error("reserved bits not zero");
    a_ext_fixed: assert property (s_rd |=> cfg_rsp_o.rdata[23:22] == 2'h3)
        else $error("extension bits wrong");
    a_enable_gate: assert property (!wake_context_keep_o |-> wake_pin_oe_b_o)
        else $error("wake driven while disabled");
    a_flag_set: assert property (wake_event_i |=> !wake_context_keep_o || !wake_pin_oe_b_o)
        else $error("wake event not driven");
    a_state_write: assert property (s_wr_lo ##0 $past(pci_bus_reset_pin_b_i, 2)
        |=> power_state_o == $past(cfg_req_i.wdata[1:0])) else $error("power state not written");
    a_d0_pulse: assert property (s_wr_lo ##0 (cfg_req_i.wdata[1:0] == 2'h0
        && power_state_o == 2'h3) |=> func_reset_o ##1 !func_reset_o) else $error("no reset pulse");
    a_clock_stop: assert property (sec_clock_stop_o == (power_state_o == 2'h3)
        && !sec_power_off_o && !wake_pin_o) else $error("secondary bus action wrong");
    a_bus_reset: assert property (!pci_bus_reset_pin_b_i [*5] |-> power_state_o == 2'h0)
        else $error("bus reset kept state");
endmodule

bind cbpm_regs cbpm_regs_props u_props (.clk_i, .rst_b_i, .pci_bus_reset_pin_b_i,
    .cfg_req_i, .cfg_rsp_o, .wake_event_i, .wake_pin_o, .wake_pin_oe_b_o, .power_state_o,
    .func_reset_o, .wake_context_keep_o, .sec_clock_stop_o, .sec_power_off_o);

// ==== dv/cbpm_host.sv ====
// Configuration host model issuing one read or write at a time.
// Assumes its tasks are called from the bench's main sequence.
`timescale 1ns/1ps
module cbpm_host (
    input  wire logic                    clk_i,
    input  wire cbpm_pkg::cbpm_cfg_rsp_t rsp_i,
    output cbpm_pkg::cbpm_cfg_req_t      req_o
);
    initial req_o = '0;
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'h1, rd: 1'h0, addr: a, be: b, wdata: d};
        @(posedge clk_i);
        // Released lines show the inverse so a stale value never passes.
        req_o <= '{wr: 1'h0, rd: 1'h0, addr: ~a, be: ~b, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h1, addr: a, be: 4'hF, wdata: 32'h0};
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h0, addr: ~a, be: 4'h0, wdata: 32'hFFFFFFFF};
        #1;
        ok = rsp_i.valid;
        d = rsp_i.rdata;
    endtask
endmodule

// ==== dv/cbpm_regs_tb_top.sv ====
// Self-checking bench for the power-management register bank.
// Assumes the host model drives configuration cycles on a 40 MHz clock.
`timescale 1ns/1ps
module cbpm_regs_tb_top;
    logic clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic bus_b = 1'h1;
    logic ev_i = 1'h0;
    logic oe_b;
    logic stop;
    logic frst;
    logic poff;
    logic keep;
    cbpm_pkg::cbpm_cfg_req_t req;
    cbpm_pkg::cbpm_cfg_rsp_t rsp;
    int error_cnt = 0, n_tests = 0, st = 0, en = 0, fl = 0, cap = 1;
    logic [31:0] seed = 32'h0DBA;
    initial forever #12.5 clk_i = ~clk_i;
    cbpm_host u_host (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));
    cbpm_regs dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .pci_bus_reset_pin_b_i(bus_b),
        .cfg_req_i(req), .cfg_rsp_o(rsp), .wake_event_i(ev_i), .wake_pin_o(),
        .wake_pin_oe_b_o(oe_b), .power_state_o(), .func_reset_o(frst),
        .wake_context_keep_o(keep), .sec_clock_stop_o(stop), .sec_power_off_o(poff));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_of(input logic [7:0] a);
        if (a == 8'hA4) return {8'h00, 8'hC0, 1'(fl), 6'h00, 1'(en), 6'h00, 2'(st)};
        if (a == 8'hA0) return {1'(cap), 15'h7E12, 16'h0000};
        return 32'h0;
    endfunction
    task automatic close_out();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a);
        logic [31:0] v;
        logic ok;
        u_host.rd(a, v, ok);
        if (ok !== 1'h1) begin
            error_cnt++;
            close_out();
        end
        chk("read data", exp_of(a), v);
    endtask
    task automatic hw(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        u_host.wr(a, b, d);
        #1;
        if (a == 8'hA4 && b[0]) begin
            chk_pin("internal reset", st == 3 && d[1:0] == 2'h0, frst);
            st = d[1:0];
        end
        if (a == 8'hA4 && b[1]) en = d[8];
        if (a == 8'hA4 && b[1] && d[15]) fl = 0;
        if (a == 8'hA0 && b[3]) cap = d[31];
    endtask
    task automatic ev();
        @(posedge clk_i);
        ev_i <= 1'h1;
        @(posedge clk_i);
        ev_i <= 1'h0;
        fl = 1;
        #1;
        chk_pin("wake drive", !(fl && en), oe_b);
    endtask
    task automatic br();
        @(posedge clk_i);
        bus_b <= 1'h0;
        repeat (6) @(posedge clk_i);
        bus_b <= 1'h1;
        repeat (4) @(posedge clk_i);
        st = 0;
        if (en == 0) fl = 0;
        chk_pin("context keep", en != 0, keep);
    endtask
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'h1;
        rc(8'hA4);
        rc(8'hA0);
        rc(8'hB0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            hw(8'hA4, 4'hF, {seed[31:2], 2'(i)});
            rc(8'hA4);
            chk_pin("clock stop", st == 3, stop);
            chk_pin("power off", 1'h0, poff);
        end
        hw(8'hA4, 4'h3, 32'h00000100);
        ev();
        hw(8'hA4, 4'h2, 32'h00000100);
        rc(8'hA4);
        hw(8'hA4, 4'h2, 32'h00008100);
        chk_pin("wake clear", 1'h1, oe_b);
        ev();
        hw(8'hA4, 4'h1, 32'h00000002);
        br();
        rc(8'hA4);
        hw(8'hA4, 4'h2, 32'h00000000);
        ev();
        br();
        rc(8'hA4);
        hw(8'hA0, 4'h8, 32'h00000000);
        rc(8'hA0);
        hw(8'hA4, 4'h2, 32'h00000100);
        @(posedge clk_i);
        rst_b_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'h1;
        {cap, en, fl, st} = {32'd1, 32'd0, 32'd0, 32'd0};
        rc(8'hA0);
        rc(8'hA4);
        close_out();
    end
endmodule
